// ===== hdl/spp_port.sv
// Purpose: byte-wide serial peripheral port, master or slave, behind APB
// Assumes: serial pins are synchronous to core_clk; one clock domain
// Notes: slave clock must stay well below core_clk/4 for edges to be seen
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - port does nothing unless the enable control bit is one
// - control bit six chooses slave (zero) or master (one)
// - control bit five sets the serial clock idle level
// - control bit four picks sampling on first or second clock edge
// - control bit three makes the port honour or ignore slave select
// - control bit two picks most or least significant bit first
// - master clock is core clock divided by 2, 4, 8 or 16
// - transfer done flag sets when each transfer ends
// - transfer done flag clears when its interrupt is vectored
// - writing zero clears transfer done flag, writing one does nothing
// - data write during a transfer sets the write collision flag
// - collision flag clears by writing zero or a data write when idle
// - master data write loads shifter and starts; data read gives receive buffer
// - busy status bit is high throughout a transfer
// - receive full sets at transfer end; clears by zero write or data read
// - honoured select low in master mode flags fault, clears enable and master
module spp_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt side
    input wire logic vector_ack,
    output logic irq,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // master out, slave in pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // master in, slave out pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // slave select pin
    input wire logic ss_in_n
);
    function automatic logic out_bit(input logic [7:0] sr, input logic low_bit_first);
        out_bit = low_bit_first ? sr[0] : sr[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                            input logic low_bit_first);
        shift_in = low_bit_first ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction : shift_in

    logic [7:0] ctrl_q;
    logic done_q, write_collision_flag_q, mode_fault_flag_q, rcvf_q;
    logic [7:0] rxbuf_q, sr_q;
    logic smp_q, sck_q, sck_prev_q;
    logic [3:0] cnt_q;
    logic [2:0] div_q;
    logic [2:0] irqst_q, mask_q;
    spp_pkg::spp_state_type state_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    logic sck_oe_q, mosi_q, mosi_oe_q, miso_q, miso_oe_q;

    // control fields
    logic en, mst, cpol, cpha, ssi, low_bit_first;
    logic [1:0] rate;
    assign en = ctrl_q[spp_pkg::SPP_EN_BIT];
    assign mst = ctrl_q[spp_pkg::SPP_MASTER_SELECT_BIT];
    assign cpol = ctrl_q[spp_pkg::SPP_CPOL_BIT];
    assign cpha = ctrl_q[spp_pkg::SPP_CPHA_BIT];
    assign ssi = ctrl_q[spp_pkg::SPP_SSI_BIT];
    assign low_bit_first = ctrl_q[spp_pkg::SPP_LOW_BIT_FIRST_BIT];
    assign rate = ctrl_q[spp_pkg::SPP_RATE_HI:spp_pkg::SPP_RATE_LO];

    // bus decode; effects land on the access edge only
    logic setup, access, wr, rd, mapped;
    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign mapped = paddr == spp_pkg::SPP_CTRL_ADDR || paddr == spp_pkg::SPP_STAT_ADDR ||
                    paddr == spp_pkg::SPP_DATA_ADDR || paddr == spp_pkg::SPP_IRQ_STAT_ADDR ||
                    paddr == spp_pkg::SPP_IRQ_MASK_ADDR;
    logic wr_ctrl, wr_stat, wr_data, rd_data, rd_irq;
    assign wr_ctrl = wr && paddr == spp_pkg::SPP_CTRL_ADDR;
    assign wr_stat = wr && paddr == spp_pkg::SPP_STAT_ADDR;
    assign wr_data = wr && paddr == spp_pkg::SPP_DATA_ADDR;
    assign rd_data = rd && paddr == spp_pkg::SPP_DATA_ADDR;
    assign rd_irq = rd && paddr == spp_pkg::SPP_IRQ_STAT_ADDR;

    // serial engine events, shared by both roles
    logic busy, selected, mfault, start, m_edge, s_edge, lead, trail;
    logic sample_ev, shift_ev, done_ev, in_bit, fin_bit;
    assign busy = state_q == spp_pkg::SPP_RUN;
    assign selected = ssi || !ss_in_n;
    assign mfault = en && mst && !ssi && !ss_in_n;
    assign start = wr_data && !busy && en && mst && !mfault;
    assign m_edge = busy && mst && div_q == spp_pkg::SPP_HALF_M1[rate];
    // slave edges come from the external master's clock pin
    assign s_edge = busy && !mst && selected && sck_in != sck_prev_q;
    assign lead = mst ? (m_edge && sck_q == cpol) : (s_edge && sck_prev_q == cpol);
    assign trail = mst ? (m_edge && sck_q != cpol) : (s_edge && sck_prev_q != cpol);
    assign sample_ev = cpha ? trail : lead;
    assign done_ev = cpha ? (trail && cnt_q == spp_pkg::SPP_BITS_LAST)
                          : (trail && cnt_q == spp_pkg::SPP_BITS_ALL);
    // second-edge mode has no leading shift edge after the last bit
    assign shift_ev = cpha ? ((lead && cnt_q != 4'h0) || done_ev) : trail;
    assign in_bit = mst ? miso_in : mosi_in;
    assign fin_bit = (cpha && done_ev) ? in_bit : smp_q;

    // control register; a mode fault knocks out enable and master
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= spp_pkg::SPP_CTRL_RST;
        end else if (mfault) begin
            ctrl_q <= ctrl_q & ~(8'h01 << spp_pkg::SPP_EN_BIT) & ~(8'h01 << spp_pkg::SPP_MASTER_SELECT_BIT);
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // transfer state; disable or deselect aborts a transfer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= spp_pkg::SPP_IDLE;
        end else if (!en || mfault || (busy && !mst && !selected)) begin
            state_q <= spp_pkg::SPP_IDLE;
        end else begin
            unique case (state_q)
                spp_pkg::SPP_IDLE: begin
                    if (start || (!mst && selected && sck_in != sck_prev_q)) begin
                        state_q <= spp_pkg::SPP_RUN;
                    end
                end
                spp_pkg::SPP_RUN: begin
                    if (done_ev) begin
                        state_q <= spp_pkg::SPP_IDLE;
                    end
                end
            endcase
        end
    end

    // idle slave edge that starts a transfer is also its first edge
    logic s_first_lead;
    assign s_first_lead = !busy && en && !mst && selected && sck_in != sck_prev_q
                          && sck_prev_q == cpol && !cpha;

    // bit counter and sample latch; the starting slave edge must not lose bit one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            smp_q <= 1'b0;
        end else if (s_first_lead) begin
            cnt_q <= 4'h1;
            smp_q <= in_bit;
        end else if (!busy || done_ev) begin
            cnt_q <= 4'h0;
        end else if (sample_ev) begin
            cnt_q <= cnt_q + 4'h1;
            smp_q <= in_bit;
        end
    end

    // shift register: loaded by a data write, shifted per bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= 8'h00;
        end else if (wr_data && !busy) begin
            sr_q <= pwdata[7:0];
        end else if (shift_ev) begin
            sr_q <= shift_in(sr_q, fin_bit, low_bit_first);
        end
    end

    // master clock divider and clock level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 3'h0;
            sck_q <= 1'b0;
        end else if (!busy || !mst || m_edge) begin
            div_q <= 3'h0;
            sck_q <= (busy && mst) ? !sck_q : cpol;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // slave view of the clock pin, one cycle back
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= (en && !mst && selected) ? sck_in : cpol;
        end
    end

    // pin drivers; output bit follows the shifter when idle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_oe_q <= 1'b0;
            mosi_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            sck_oe_q <= en && mst && !mfault;
            mosi_oe_q <= en && mst && !mfault;
            miso_oe_q <= en && !mst && selected;
            if (shift_ev && !done_ev) begin
                mosi_q <= out_bit(shift_in(sr_q, fin_bit, low_bit_first), low_bit_first);
                miso_q <= out_bit(shift_in(sr_q, fin_bit, low_bit_first), low_bit_first);
            end else if (!busy) begin
                // a data write shows its first bit at once, else bit one goes out stale
                mosi_q <= out_bit(wr_data ? pwdata[7:0] : sr_q, low_bit_first);
                miso_q <= out_bit(wr_data ? pwdata[7:0] : sr_q, low_bit_first);
            end
        end
    end

    // receive buffer captures the finished byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_q <= 8'h00;
        end else if (done_ev) begin
            rxbuf_q <= shift_in(sr_q, fin_bit, low_bit_first);
        end
    end

    // status flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            mode_fault_flag_q <= 1'b0;
            rcvf_q <= 1'b0;
        end else begin
            if (done_ev) begin
                done_q <= 1'b1;
            end else if (vector_ack) begin
                done_q <= 1'b0;
            end else if (wr_stat && !pwdata[spp_pkg::SPP_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (wr_data && busy) begin
                write_collision_flag_q <= 1'b1;
            end else if ((wr_stat && !pwdata[spp_pkg::SPP_WRITE_COLLISION_FLAG_BIT]) || wr_data) begin
                write_collision_flag_q <= 1'b0;
            end
            if (mfault) begin
                mode_fault_flag_q <= 1'b1;
            end else if (wr_stat && !pwdata[spp_pkg::SPP_MODE_FAULT_FLAG_BIT]) begin
                mode_fault_flag_q <= 1'b0;
            end
            if (done_ev) begin
                rcvf_q <= 1'b1;
            end else if (rd_data || (wr_stat && !pwdata[spp_pkg::SPP_RCVF_BIT])) begin
                rcvf_q <= 1'b0;
            end
        end
    end

    // interrupt status cleared by reading it, gated by the mask
    logic [2:0] ev;
    assign ev = {mfault, wr_data && busy, done_ev};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqst_q <= 3'h0;
            mask_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            irqst_q <= (rd_irq ? 3'h0 : irqst_q) | ev;
            if (wr && paddr == spp_pkg::SPP_IRQ_MASK_ADDR) begin
                mask_q <= pwdata[spp_pkg::SPP_IRQ_W-1:0];
            end
            irq_q <= |(((rd_irq ? 3'h0 : irqst_q) | ev) & mask_q);
        end
    end

    // apb answer: data prepared in setup, ready for exactly one cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                unique case (paddr)
                    spp_pkg::SPP_CTRL_ADDR: prdata_q <= {24'h000000, ctrl_q};
                    spp_pkg::SPP_STAT_ADDR: prdata_q <= {24'h000000, done_q, write_collision_flag_q, mode_fault_flag_q,
                                                         1'b0, rcvf_q, busy, 2'h0};
                    spp_pkg::SPP_DATA_ADDR: prdata_q <= {24'h000000, rxbuf_q};
                    spp_pkg::SPP_IRQ_STAT_ADDR: prdata_q <= {29'h00000000, irqst_q};
                    spp_pkg::SPP_IRQ_MASK_ADDR: prdata_q <= {29'h00000000, mask_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign sck_out = sck_q;
    assign sck_oe = sck_oe_q;
    assign mosi_out = mosi_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_out = miso_q;
    assign miso_oe = miso_oe_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_disable_stops_busy: assert property (!en |=> !busy)
        else $error("port busy while disabled");
    a_master_drives_clock: assert property ((en && mst && !mfault) |=> sck_oe)
        else $error("master does not drive clock pin");
    a_idle_clock_level: assert property ((!busy && !start) ##1 !busy |-> sck_out == $past(cpol))
        else $error("idle clock level wrong");
    a_rate_divider: assert property ((busy && mst && !mfault && en && div_q == spp_pkg::SPP_HALF_M1[rate] && !done_ev)
        |=> sck_out != $past(sck_out))
        else $error("master clock did not toggle at divider end");
    a_done_sets_flag: assert property (done_ev |=> done_q && rcvf_q)
        else $error("transfer end did not set flags");
    a_collision_flag: assert property ((wr_data && busy && !shift_ev) |=> write_collision_flag_q && $stable(sr_q))
        else $error("collision not flagged or shifter disturbed");
    a_fault_drops_mode: assert property (mfault |=> mode_fault_flag_q && !en && !mst && !busy)
        else $error("mode fault handling wrong");
    a_busy_reads_back: assert property ((setup && paddr == spp_pkg::SPP_STAT_ADDR)
        |=> prdata[spp_pkg::SPP_BUSY_BIT] == $past(busy))
        else $error("busy status bit mismatch");
    a_eight_bit_count: assert property (done_ev |-> cnt_q == (cpha ? spp_pkg::SPP_BITS_LAST
        : spp_pkg::SPP_BITS_ALL))
        else $error("transfer ended at wrong bit count");
    a_read_clears_full: assert property ((rd_data && !done_ev) |=> !rcvf_q)
        else $error("data read left receive full set");
endmodule : spp_port
`default_nettype wire

// ===== hdl/spp_pkg.sv
// Purpose: shared constants and types for the serial peripheral port
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: byte address of each register is four times its index
package spp_pkg;
    // register indices and their APB byte addresses
    localparam logic [7:0] SPP_CTRL_IDX = 8'hBC;
    localparam logic [7:0] SPP_STAT_IDX = 8'hBD;
    localparam logic [7:0] SPP_DATA_IDX = 8'hBE;
    localparam logic [7:0] SPP_IRQ_STAT_IDX = 8'hBF;
    localparam logic [7:0] SPP_IRQ_MASK_IDX = 8'hC0;
    localparam int SPP_ADDR_W = 12;
    localparam logic [11:0] SPP_CTRL_ADDR = {2'h0, SPP_CTRL_IDX, 2'h0};
    localparam logic [11:0] SPP_STAT_ADDR = {2'h0, SPP_STAT_IDX, 2'h0};
    localparam logic [11:0] SPP_DATA_ADDR = {2'h0, SPP_DATA_IDX, 2'h0};
    localparam logic [11:0] SPP_IRQ_STAT_ADDR = {2'h0, SPP_IRQ_STAT_IDX, 2'h0};
    localparam logic [11:0] SPP_IRQ_MASK_ADDR = {2'h0, SPP_IRQ_MASK_IDX, 2'h0};

    // control register fields
    localparam int SPP_EN_BIT = 7;
    localparam int SPP_MASTER_SELECT_BIT = 6;
    localparam int SPP_CPOL_BIT = 5;
    localparam int SPP_CPHA_BIT = 4;
    localparam int SPP_SSI_BIT = 3;
    localparam int SPP_LOW_BIT_FIRST_BIT = 2;
    localparam int SPP_RATE_HI = 1;
    localparam int SPP_RATE_LO = 0;
    localparam logic [7:0] SPP_CTRL_RST = 8'h00;

    // status register fields
    localparam int SPP_DONE_BIT = 7;
    localparam int SPP_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int SPP_MODE_FAULT_FLAG_BIT = 5;
    localparam int SPP_RCVF_BIT = 3;
    localparam int SPP_BUSY_BIT = 2;

    // interrupt status and mask layout
    localparam int SPP_IRQ_DONE = 0;
    localparam int SPP_IRQ_WRITE_COLLISION_FLAG = 1;
    localparam int SPP_IRQ_MODE_FAULT_FLAG = 2;
    localparam int SPP_IRQ_W = 3;

    // half period of the serial clock minus one, in core clocks, per rate code
    localparam logic [2:0] SPP_HALF_M1 [0:3] = '{3'h0, 3'h1, 3'h3, 3'h7};
    localparam logic [3:0] SPP_BITS_LAST = 4'h7;
    localparam logic [3:0] SPP_BITS_ALL = 4'h8;

    typedef enum logic [1:0] {
        SPP_IDLE = 2'b01,
        SPP_RUN = 2'b10
    } spp_state_type;
endpackage : spp_pkg

// ===== bench/spp_peer_model.sv
// Purpose: peer serial device facing the port in master mode
// Assumes: mode inputs match the port setup; tx settles before select
// Notes: released output flips so a stale bit never reads as data
`timescale 1ns/1ps
`default_nettype none
module spp_peer_model (
    // serial pins
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    // mode and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic low_bit_first,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    int k = 0;
    // next outgoing bit in the chosen order
    task automatic put();
        miso = low_bit_first ? tx[k] : tx[7 - k];
        k++;
    endtask : put
    initial begin
        miso = 1'b0;
        rx = 8'h00;
    end
    // phase zero shows the first bit at select
    always @(negedge sel_n) begin
        k = 0;
        if (!cpha) put();
    end
    always @(posedge sel_n) miso = ~miso;
    // leading edge leaves idle level; phase picks sample edge
    always @(sck) if (!sel_n) begin
        if ((sck != cpol) == !cpha) rx = low_bit_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        else if (k < 8) put();
    end
endmodule : spp_peer_model
`default_nettype wire

// ===== bench/serial_peripheral_port_tb.sv
// Purpose: self-checking bench for the serial peripheral port
// Assumes: peer model in master mode; bench is the master in slave mode
// Notes: expectations are reckoned here, never read back from the port
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_tb;
    localparam logic [11:0] A_CTRL = spp_pkg::SPP_CTRL_ADDR;
    localparam logic [11:0] A_STAT = spp_pkg::SPP_STAT_ADDR;
    localparam logic [11:0] A_DATA = spp_pkg::SPP_DATA_ADDR;
    localparam logic [11:0] A_ISTAT = spp_pkg::SPP_IRQ_STAT_ADDR;
    localparam logic [11:0] A_MASK = spp_pkg::SPP_IRQ_MASK_ADDR;
    logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic vector_ack = 1'b0, ss_in_n = 1'b1, sel_n = 1'b1, m_sck = 1'b0, m_mosi = 1'b0;
    logic cpol = 1'b0, cpha = 1'b0, low_bit_first = 1'b0, sck_prev = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic [7:0] s_tx = 8'h00, s_rx;
    wire logic sck, mosi, miso, p_miso;
    int n_errors = 0, samples_checked = 0, seed = 32'h9B835991;
    int n_tog = 0, cyc = 0, t_first = 0, t_last = 0;
    // whichever party enables drives the wire
    assign sck = sck_oe ? sck_out : m_sck;
    assign mosi = mosi_oe ? mosi_out : m_mosi;
    assign miso = miso_oe ? miso_out : p_miso;
    always #2 core_clk = ~core_clk;
    spp_port dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vector_ack(vector_ack), .irq(irq), .sck_in(sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_in_n(ss_in_n));
    spp_peer_model peer (.sck(sck), .sel_n(sel_n), .mosi(mosi), .miso(p_miso),
        .cpol(cpol), .cpha(cpha), .low_bit_first(low_bit_first), .tx(s_tx), .rx(s_rx));
    // toggle count and span judge rate and bit count
    always @(posedge core_clk) begin
        cyc++;
        if (sck_out !== sck_prev) begin
            if (n_tog == 0) t_first = cyc;
            t_last = cyc;
            n_tog++;
        end
        sck_prev = sck_out;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // pready is sampled at the rising edge, and the answer is taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++t < 50);
        if (t == 50) chk("pready", 32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q, r;
        logic e;
        q = $random(seed);
        apb(1'b1, a, {q[31:8], d}, r, e);
    endtask : wr
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask : rd
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        logic [31:0] r;
        logic e, col;
        logic [7:0] wd, md, got;
        logic [2:0] mk;
        int k;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd("ctrl reset", A_CTRL, 32'h0);
        rd("stat reset", A_STAT, 32'h0);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        // every rate, polarity, phase and order against the peer
        for (int m = 0; m < 32; m++) begin
            col = (m[1:0] == 2'h3);
            r = $random(seed);
            mk = r[2:0];
            wd = r[15:8];
            s_tx <= r[23:16];
            sel_n <= 1'b1;
            {cpol, cpha, low_bit_first} <= {m[4], m[3], m[2]};
            wr(A_CTRL, {2'h3, m[4], m[3], 1'b0, m[2], m[1:0]});
            wr(A_MASK, {5'h0, mk});
            sel_n <= 1'b0;
            n_tog = 0;
            wr(A_DATA, wd);
            rd("busy", A_STAT, 32'h4);
            if (col) begin
                wr(A_DATA, ~wd);
                rd("collide", A_STAT, 32'h44);
            end
            k = 0;
            do apb(1'b0, A_STAT, 32'h0, r, e); while (r[7] !== 1'b1 && ++k < 100);
            chk("done", {24'h0, 1'b1, col, 6'h08}, r);
            chk("irq", {31'h0, |(mk & {1'b0, col, 1'b1})}, {31'h0, irq});
            rd("irq stat", A_ISTAT, {30'h0, col, 1'b1});
            chk("irq clr", 32'h0, {31'h0, irq});
            rd("rx data", A_DATA, {24'h0, s_tx});
            rd("rx read", A_STAT, {24'h0, 1'b1, col, 6'h00});
            wr(A_STAT, 8'hFF);
            rd("ones", A_STAT, {24'h0, 1'b1, col, 6'h00});
            if (m[0]) begin
                vector_ack <= 1'b1;
                @(posedge core_clk);
                vector_ack <= 1'b0;
                @(posedge core_clk);
            end
            else wr(A_STAT, 8'h40);
            rd("done clr", A_STAT, {24'h0, 1'b0, col, 6'h00});
            chk("peer rx", {24'h0, wd}, {24'h0, s_rx});
            chk("toggles", 32'h10, n_tog);
            chk("span", 32'hF << m[1:0], t_last - t_first);
            chk("idle", {31'h0, m[4]}, {31'h0, sck_out});
        end
        // select low against a master, ignored then honoured
        sel_n <= 1'b1;
        wr(A_STAT, 8'h00);
        wr(A_CTRL, 8'hC8);
        ss_in_n <= 1'b0;
        rd("ss ignored", A_CTRL, 32'hC8);
        wr(A_CTRL, 8'hC0);
        rd("fault ctrl", A_CTRL, 32'h0);
        rd("fault stat", A_STAT, 32'h20);
        rd("fault irq", A_ISTAT, 32'h4);
        ss_in_n <= 1'b1;
        wr(A_STAT, 8'h00);
        // a data write with the port off starts nothing
        wr(A_CTRL, 8'h40);
        wr(A_DATA, 8'h5A);
        rd("off stat", A_STAT, 32'h0);
        // slave transfer with the bench as master
        r = $random(seed);
        wd = r[7:0];
        md = r[15:8];
        wr(A_CTRL, 8'h80);
        wr(A_DATA, wd);
        ss_in_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            m_mosi <= md[i];
            repeat (4) @(posedge core_clk);
            m_sck <= 1'b1;
            got[i] = miso;
            repeat (4) @(posedge core_clk);
            m_sck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        ss_in_n <= 1'b1;
        k = 0;
        do apb(1'b0, A_STAT, 32'h0, r, e); while (r[7] !== 1'b1 && ++k < 20);
        chk("slave done", 32'h1, {31'h0, r[7]});
        chk("slave tx", {24'h0, wd}, {24'h0, got});
        rd("slave rx", A_DATA, {24'h0, md});
        end_sim();
    end
endmodule : serial_peripheral_port_tb
`default_nettype wire
